/* File: rtl/mpdc_pkg.sv */
// constants and types shared by both ends of the module power-down control link
// assumes one 125 MHz clock, ref_clk, on both ends
package mpdc_pkg;

  // ****************************************
  // device register map
  // ****************************************
  localparam logic [7:0] REG0_OFS = 8'hB0;
  localparam logic [7:0] REG3_OFS = 8'hC7;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int APD_EN_BIT = 1;
  localparam int TURBO_OFF_BIT = 3;
  localparam int FORCED_POWERDOWN_BIT_BIT = 1;
  localparam logic [7:0] REG3_USED_MASK = 8'h02;
  localparam logic [7:0] FORCED_POWERDOWN_BIT_VALUE = 8'h02;

  // ****************************************
  // power-down counter and timing
  // ****************************************
  localparam int CNT_W = 4;
  localparam logic [3:0] APD_ZERO = 4'h0;
  localparam logic [3:0] APD_ONE = 4'h1;
  localparam logic [3:0] APD_MAX = 4'hF;
  localparam int CLK_PERIOD_NS = 8;
  localparam int IDLE_5V_NS = 65;
  localparam int IDLE_3V3_NS = 100;
  localparam int IDLE_5V_CYC = (IDLE_5V_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int IDLE_3V3_CYC = (IDLE_3V3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int IDLE_W = 4;

  // ****************************************
  // pins crossing into the device
  // ****************************************
  localparam int PIN_N = 4;
  localparam int PIN_ALE = 0;
  localparam int PIN_COMMON_CLOCK_INPUT = 1;
  localparam int PIN_CS_N = 2;
  localparam int PIN_RST_N = 3;
  localparam logic [3:0] PIN_RESET = 4'hC;
  localparam int SEL_N = 4;

  // ****************************************
  // controller wishbone registers
  // ****************************************
  localparam logic [3:0] WB_CTRL = 4'h0;
  localparam logic [3:0] WB_CMD = 4'h4;
  localparam logic [3:0] WB_STAT = 4'h8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0004;
  localparam int CTRL_ALE_RUN = 0;
  localparam int CTRL_CS_N = 1;
  localparam int CTRL_RST_N = 2;
  localparam int CTRL_COMMON_CLOCK_INPUT_RUN = 3;
  localparam int CMD_DATA_LSB = 0;
  localparam int CMD_ADDR_LSB = 8;
  localparam int CMD_READ_BIT = 16;
  localparam int CMD_FORCE_BIT = 17;
  localparam int STAT_BUSY = 0;
  localparam int STAT_PDN = 1;
  localparam int STAT_SLEEP = 2;
  localparam int STAT_WAIT = 3;
  localparam int STAT_RD_LSB = 8;

  typedef enum logic [2:0] {
    MPDC_H_IDLE = 3'b001,
    MPDC_H_ISSUE = 3'b010,
    MPDC_H_WAIT = 3'b100
  } mpdc_hstate_t;

endpackage : mpdc_pkg

/* File: rtl/mpdc_if.sv */
// link between the module power-down logic and the host core that drives it
// assumes both ends run on the same ref_clk; pin-like signals are resynchronised by the device
`timescale 1ns/1ns
interface mpdc_if;
  logic ale;
  logic common_clock_input;
  logic csN;
  logic rstN;
  logic regWr;
  logic regRd;
  logic [7:0] regAddr;
  logic [7:0] regWdata;
  logic [7:0] regRdata;
  logic regRvalid;
  logic power_down_indicator;
  logic turboOff;

  modport dev (
    input ale, common_clock_input, csN, rstN, regWr, regRd, regAddr, regWdata,
    output regRdata, regRvalid, power_down_indicator, turboOff
  );
  modport host (
    output ale, common_clock_input, csN, rstN, regWr, regRd, regAddr, regWdata,
    input regRdata, regRvalid, power_down_indicator, turboOff
  );
endinterface : mpdc_if

/* File: rtl/mpdc_device.sv */
// power-down control of the memory and logic-array module
// assumes the host end drives the link on ref_clk; ale, common_clock_input, csN, rstN are treated as pins
//
// Notes on behaviour
// - enabled idle bus: 4-bit counter counts common_clock_input
// - fifteen idle common_clock_input periods raise power-down
// - any ale edge before max clears counter
// - ale steady high or low both count
// - power-down blocks bus from memories, logic
// - wake on ale, chip-select fall, reset rise
// - memories standby; logic outputs held
// - host core ports never touched
// - indicator feeds logic and select terms
// - forced bit sets power-down immediately
// - forced bit cleared only by reset
// - enable and turbo bits cleared at power-up only
// - software writes zero to unused bits
// - host runs queued forced power-down sequence
// - host core then sleeps itself
// - chip select active low, only when configured
// - chip select high blocks every memory select
// - turbo off: logic standby after idle time
// - host adds wait state when turbo off
// - turbo bit defaults to zero, turbo on
// - block inputs only when unused
// - slow common_clock_input chosen to avoid false timeouts
`timescale 1ns/1ns
module mpdc_device #(
  parameter bit LOW_VOLTAGE = 1'b0
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  mpdc_if.dev link,
  input wire logic csiEnable,
  input wire logic [mpdc_pkg::SEL_N-1:0] memDecode,
  input wire logic logicActive,
  output logic [mpdc_pkg::SEL_N-1:0] memSelect,
  output logic powerDownIndicator,
  output logic memStandby,
  output logic busBlock,
  output logic logicStandby
);

  localparam int IDLE_CYC = LOW_VOLTAGE ? mpdc_pkg::IDLE_3V3_CYC : mpdc_pkg::IDLE_5V_CYC;
  localparam logic [mpdc_pkg::IDLE_W-1:0] IDLE_LIMIT = IDLE_CYC[mpdc_pkg::IDLE_W-1:0];
  localparam logic [mpdc_pkg::IDLE_W-1:0] IDLE_ONE = {{(mpdc_pkg::IDLE_W-1){1'b0}}, 1'b1};

  function automatic logic rose(input logic now, input logic was);
    rose = now & ~was;
  endfunction : rose

  function automatic logic fell(input logic now, input logic was);
    fell = ~now & was;
  endfunction : fell

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [mpdc_pkg::PIN_N-1:0] pinRaw;
  logic [mpdc_pkg::PIN_N-1:0] s1Ff;
  logic [mpdc_pkg::PIN_N-1:0] s2Ff;
  logic [mpdc_pkg::PIN_N-1:0] s3Ff;
  logic [mpdc_pkg::PIN_N-1:0] pinFf;
  logic [mpdc_pkg::PIN_N-1:0] prevFf;

  assign pinRaw[mpdc_pkg::PIN_ALE] = link.ale;
  assign pinRaw[mpdc_pkg::PIN_COMMON_CLOCK_INPUT] = link.common_clock_input;
  assign pinRaw[mpdc_pkg::PIN_CS_N] = link.csN;
  assign pinRaw[mpdc_pkg::PIN_RST_N] = link.rstN;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s1Ff <= mpdc_pkg::PIN_RESET;
      s2Ff <= mpdc_pkg::PIN_RESET;
      s3Ff <= mpdc_pkg::PIN_RESET;
    end else if (clkEn) begin
      s1Ff <= pinRaw;
      s2Ff <= s1Ff;
      s3Ff <= s2Ff;
    end
  end

  // a level counts only once the second and third stage agree
  genvar gi;
  generate
    for (gi = 0; gi < mpdc_pkg::PIN_N; gi++) begin : g_filt
      always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
          pinFf[gi] <= mpdc_pkg::PIN_RESET[gi];
          prevFf[gi] <= mpdc_pkg::PIN_RESET[gi];
        end else if (clkEn) begin
          if (s2Ff[gi] == s3Ff[gi]) begin
            pinFf[gi] <= s3Ff[gi];
          end
          prevFf[gi] <= pinFf[gi];
        end
      end
    end
  endgenerate

  logic clkTick;
  logic aleEdge;
  logic csWake;
  logic rstRise;
  logic wake;

  assign clkTick = rose(pinFf[mpdc_pkg::PIN_COMMON_CLOCK_INPUT], prevFf[mpdc_pkg::PIN_COMMON_CLOCK_INPUT]);
  assign aleEdge = rose(pinFf[mpdc_pkg::PIN_ALE], prevFf[mpdc_pkg::PIN_ALE])
                 | fell(pinFf[mpdc_pkg::PIN_ALE], prevFf[mpdc_pkg::PIN_ALE]);
  assign csWake = csiEnable & fell(pinFf[mpdc_pkg::PIN_CS_N], prevFf[mpdc_pkg::PIN_CS_N]);
  assign rstRise = rose(pinFf[mpdc_pkg::PIN_RST_N], prevFf[mpdc_pkg::PIN_RST_N]);
  assign wake = aleEdge | csWake | rstRise;

  // ****************************************
  // mode registers
  // ****************************************
  logic apdEnFf;
  logic turboOffFf;
  logic forcePdFf;
  logic wrReg0;
  logic wrReg3;

  assign wrReg0 = link.regWr & (link.regAddr == mpdc_pkg::REG0_OFS);
  assign wrReg3 = link.regWr & (link.regAddr == mpdc_pkg::REG3_OFS);

  // only power-up clears the mode bits; module reset pulses leave them
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      apdEnFf <= mpdc_pkg::REG_RESET[mpdc_pkg::APD_EN_BIT];
      turboOffFf <= mpdc_pkg::REG_RESET[mpdc_pkg::TURBO_OFF_BIT];
    end else if (clkEn && wrReg0) begin
      apdEnFf <= link.regWdata[mpdc_pkg::APD_EN_BIT];
      turboOffFf <= link.regWdata[mpdc_pkg::TURBO_OFF_BIT];
    end
  end

  // forced bit: a write of one wins over a simultaneous module-reset release
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      forcePdFf <= mpdc_pkg::REG_RESET[mpdc_pkg::FORCED_POWERDOWN_BIT_BIT];
    end else if (clkEn) begin
      if (wrReg3 && link.regWdata[mpdc_pkg::FORCED_POWERDOWN_BIT_BIT]) begin
        forcePdFf <= 1'b1;
      end else if (rstRise) begin
        forcePdFf <= 1'b0;
      end
    end
  end

  // ****************************************
  // register read-back
  // ****************************************
  logic [7:0] reg0View;
  logic [7:0] reg3View;

  always_comb begin
    reg0View = mpdc_pkg::REG_RESET;
    reg0View[mpdc_pkg::APD_EN_BIT] = apdEnFf;
    reg0View[mpdc_pkg::TURBO_OFF_BIT] = turboOffFf;
    reg3View = mpdc_pkg::REG_RESET;
    reg3View[mpdc_pkg::FORCED_POWERDOWN_BIT_BIT] = forcePdFf;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      link.regRdata <= mpdc_pkg::REG_RESET;
      link.regRvalid <= 1'b0;
    end else if (clkEn) begin
      link.regRvalid <= link.regRd;
      if (link.regRd) begin
        if (link.regAddr == mpdc_pkg::REG0_OFS) begin
          link.regRdata <= reg0View;
        end else if (link.regAddr == mpdc_pkg::REG3_OFS) begin
          link.regRdata <= reg3View;
        end else begin
          link.regRdata <= mpdc_pkg::REG_RESET;
        end
      end
    end
  end

  // ****************************************
  // automatic power-down counter
  // ****************************************
  logic [mpdc_pkg::CNT_W-1:0] apdCntFf;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      apdCntFf <= mpdc_pkg::APD_ZERO;
    end else if (clkEn) begin
      if (!apdEnFf) begin
        apdCntFf <= mpdc_pkg::APD_ZERO;
      end else if (wake) begin
        apdCntFf <= mpdc_pkg::APD_ZERO;
      end else if (clkTick && apdCntFf != mpdc_pkg::APD_MAX) begin
        apdCntFf <= apdCntFf + mpdc_pkg::APD_ONE;
      end
    end
  end

  // ****************************************
  // power-down state and gated selects
  // ****************************************
  logic nxt_pdn;
  logic csOk;

  assign nxt_pdn = forcePdFf | (apdEnFf & (apdCntFf == mpdc_pkg::APD_MAX));
  assign csOk = ~csiEnable | ~pinFf[mpdc_pkg::PIN_CS_N];

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      powerDownIndicator <= 1'b0;
      link.power_down_indicator <= 1'b0;
      memStandby <= 1'b0;
      busBlock <= 1'b0;
      memSelect <= '0;
    end else if (clkEn) begin
      powerDownIndicator <= nxt_pdn;
      link.power_down_indicator <= nxt_pdn;
      memStandby <= nxt_pdn;
      busBlock <= nxt_pdn;
      // selects carry the indicator and chip select in their decode terms
      memSelect <= memDecode & {mpdc_pkg::SEL_N{~nxt_pdn & csOk}};
    end
  end

  // ****************************************
  // turbo control and logic standby
  // ****************************************
  logic [mpdc_pkg::IDLE_W-1:0] idleCntFf;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      idleCntFf <= '0;
      logicStandby <= 1'b0;
      link.turboOff <= 1'b0;
    end else if (clkEn) begin
      link.turboOff <= turboOffFf;
      if (!turboOffFf || logicActive) begin
        idleCntFf <= '0;
        logicStandby <= 1'b0;
      end else if (idleCntFf != IDLE_LIMIT) begin
        idleCntFf <= idleCntFf + IDLE_ONE;
      end else begin
        logicStandby <= 1'b1;
      end
    end
  end

endmodule : mpdc_device

/* File: rtl/mpdc_host.sv */
// host core end of the module power-down link, ordered over a classic wishbone slave
// assumes a wishbone master on ref_clk; never touches the core's own ports
`timescale 1ns/1ns
module mpdc_host #(
  parameter int COMMON_CLOCK_INPUT_DIV = 64,
  parameter int ALE_DIV = 2
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  mpdc_if.host link,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic coreSleep,
  output logic extraWait
);

  // ****************************************
  // wishbone decode
  // ****************************************
  logic [31:0] ctrlFf;
  logic busyFf;
  logic [7:0] rdDataFf;
  logic acc;
  logic cmdWr;
  mpdc_pkg::mpdc_hstate_t stateFf;
  logic cmdReadFf;
  logic cmdForceFf;

  assign acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign cmdWr = acc & wb_we_i & (wb_adr_i == mpdc_pkg::WB_CMD) & (&wb_sel_i[2:0]) & ~busyFf;

  // unused bits of reg0 are never set from software orders
  localparam logic [7:0] REG0_USED_MASK = (8'h01 << mpdc_pkg::APD_EN_BIT) | (8'h01 << mpdc_pkg::TURBO_OFF_BIT);

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else if (clkEn) begin
      wb_ack_o <= acc;
      wb_dat_o <= '0;
      if (acc && !wb_we_i) begin
        if (wb_adr_i == mpdc_pkg::WB_CTRL) begin
          wb_dat_o <= ctrlFf;
        end else if (wb_adr_i == mpdc_pkg::WB_STAT) begin
          wb_dat_o[mpdc_pkg::STAT_BUSY] <= busyFf;
          wb_dat_o[mpdc_pkg::STAT_PDN] <= link.power_down_indicator;
          wb_dat_o[mpdc_pkg::STAT_SLEEP] <= coreSleep;
          wb_dat_o[mpdc_pkg::STAT_WAIT] <= extraWait;
          wb_dat_o[mpdc_pkg::STAT_RD_LSB +: 8] <= rdDataFf;
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ctrlFf <= mpdc_pkg::CTRL_RESET;
    end else if (clkEn && acc && wb_we_i && wb_adr_i == mpdc_pkg::WB_CTRL && wb_sel_i[0]) begin
      ctrlFf <= {24'h00_0000, wb_dat_i[7:0] & 8'h0F};
    end
  end

  // ****************************************
  // device register access sequencer
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      stateFf <= mpdc_pkg::MPDC_H_IDLE;
      busyFf <= 1'b0;
      cmdReadFf <= 1'b0;
      cmdForceFf <= 1'b0;
      rdDataFf <= '0;
      link.regWr <= 1'b0;
      link.regRd <= 1'b0;
      link.regAddr <= '0;
      link.regWdata <= '0;
      coreSleep <= 1'b0;
      extraWait <= 1'b0;
    end else if (clkEn) begin
      link.regWr <= 1'b0;
      link.regRd <= 1'b0;
      if (acc && wb_we_i && wb_adr_i == mpdc_pkg::WB_CTRL) begin
        coreSleep <= 1'b0;
      end
      case (stateFf)
        mpdc_pkg::MPDC_H_IDLE: begin
          if (cmdWr) begin
            busyFf <= 1'b1;
            cmdReadFf <= wb_dat_i[mpdc_pkg::CMD_READ_BIT];
            cmdForceFf <= wb_dat_i[mpdc_pkg::CMD_FORCE_BIT];
            if (wb_dat_i[mpdc_pkg::CMD_FORCE_BIT]) begin
              link.regAddr <= mpdc_pkg::REG3_OFS;
              link.regWdata <= mpdc_pkg::FORCED_POWERDOWN_BIT_VALUE;
            end else begin
              link.regAddr <= wb_dat_i[mpdc_pkg::CMD_ADDR_LSB +: 8];
              if (wb_dat_i[mpdc_pkg::CMD_ADDR_LSB +: 8] == mpdc_pkg::REG3_OFS) begin
                link.regWdata <= wb_dat_i[mpdc_pkg::CMD_DATA_LSB +: 8] & mpdc_pkg::REG3_USED_MASK;
              end else if (wb_dat_i[mpdc_pkg::CMD_ADDR_LSB +: 8] == mpdc_pkg::REG0_OFS) begin
                link.regWdata <= wb_dat_i[mpdc_pkg::CMD_DATA_LSB +: 8] & REG0_USED_MASK;
              end else begin
                link.regWdata <= wb_dat_i[mpdc_pkg::CMD_DATA_LSB +: 8];
              end
            end
            stateFf <= mpdc_pkg::MPDC_H_ISSUE;
          end
        end
        mpdc_pkg::MPDC_H_ISSUE: begin
          if (cmdReadFf && !cmdForceFf) begin
            link.regRd <= 1'b1;
            stateFf <= mpdc_pkg::MPDC_H_WAIT;
          end else begin
            link.regWr <= 1'b1;
            if (link.regAddr == mpdc_pkg::REG0_OFS) begin
              extraWait <= link.regWdata[mpdc_pkg::TURBO_OFF_BIT];
            end
            // core goes to sleep in the same cycle as the forced write strobe, as from its queue
            coreSleep <= cmdForceFf;
            busyFf <= 1'b0;
            stateFf <= mpdc_pkg::MPDC_H_IDLE;
          end
        end
        mpdc_pkg::MPDC_H_WAIT: begin
          if (link.regRvalid) begin
            rdDataFf <= link.regRdata;
            busyFf <= 1'b0;
            stateFf <= mpdc_pkg::MPDC_H_IDLE;
          end
        end
        default: begin
          stateFf <= mpdc_pkg::MPDC_H_IDLE;
          busyFf <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // pin generators
  // ****************************************
  logic [15:0] clkDivFf;
  logic [15:0] aleDivFf;
  localparam logic [15:0] COMMON_CLOCK_INPUT_LAST = COMMON_CLOCK_INPUT_DIV[15:0] - 16'h0001;
  localparam logic [15:0] ALE_LAST = ALE_DIV[15:0] - 16'h0001;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      clkDivFf <= '0;
      aleDivFf <= '0;
      link.common_clock_input <= 1'b0;
      link.ale <= 1'b0;
      link.csN <= mpdc_pkg::CTRL_RESET[mpdc_pkg::CTRL_CS_N];
      link.rstN <= mpdc_pkg::CTRL_RESET[mpdc_pkg::CTRL_RST_N];
    end else if (clkEn) begin
      link.csN <= ctrlFf[mpdc_pkg::CTRL_CS_N];
      link.rstN <= ctrlFf[mpdc_pkg::CTRL_RST_N];
      if (!ctrlFf[mpdc_pkg::CTRL_COMMON_CLOCK_INPUT_RUN] || clkDivFf == COMMON_CLOCK_INPUT_LAST) begin
        clkDivFf <= '0;
        link.common_clock_input <= ctrlFf[mpdc_pkg::CTRL_COMMON_CLOCK_INPUT_RUN] & ~link.common_clock_input;
      end else begin
        clkDivFf <= clkDivFf + 16'h0001;
      end
      // ale stops at its level while the core is asleep or stopped by software
      if (!ctrlFf[mpdc_pkg::CTRL_ALE_RUN] || coreSleep || aleDivFf == ALE_LAST) begin
        aleDivFf <= '0;
        if (ctrlFf[mpdc_pkg::CTRL_ALE_RUN] && !coreSleep) begin
          link.ale <= ~link.ale;
        end
      end else begin
        aleDivFf <= aleDivFf + 16'h0001;
      end
    end
  end

endmodule : mpdc_host

/* File: dv/mpdc_chk.sv */
// checker on the link signals between the two power-down ends
// assumes it sits beside the link interface, everything on ref_clk
`timescale 1ns/1ns
module mpdc_chk (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic ale,
  input wire logic common_clock_input,
  input wire logic rstN,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regRvalid,
  input wire logic power_down_indicator,
  input wire logic turboOff
);
  logic aleD_ff, clkD_ff, rstD_ff, forced_ff, apdEn_ff;
  logic [3:0] quiet_ff;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  always_ff @(posedge ref_clk) begin
    aleD_ff <= ale;
    clkD_ff <= common_clock_input;
    rstD_ff <= rstN;
  end
  // common_clock_input rises since the last ale edge, saturating
  always_ff @(posedge ref_clk) begin
    if (sys_rst || ale != aleD_ff) quiet_ff <= 4'h0;
    else if (common_clock_input && !clkD_ff && quiet_ff != 4'hF) quiet_ff <= quiet_ff + 4'h1;
  end
  // forced bit as set by a write of one, dropped by a module reset rise
  always_ff @(posedge ref_clk) begin
    if (sys_rst || (rstN && !rstD_ff)) forced_ff <= 1'b0;
    else if (regWr && regAddr == mpdc_pkg::REG3_OFS && regWdata[mpdc_pkg::FORCED_POWERDOWN_BIT_BIT]) forced_ff <= 1'b1;
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst) apdEn_ff <= 1'b0;
    else if (regWr && regAddr == mpdc_pkg::REG0_OFS) apdEn_ff <= regWdata[mpdc_pkg::APD_EN_BIT];
  end
  chk_rd_answer: assert property (regRd |=> regRvalid)
    else $error("register read got no answer");
  chk_wr_single: assert property (regWr |=> !regWr)
    else $error("register write strobe too long");
  chk_pdn_count: assert property (
    $rose(power_down_indicator) && !forced_ff |-> apdEn_ff && quiet_ff == 4'hF)
    else $error("power-down rose without a full idle count");
  chk_ale_wake: assert property (
    power_down_indicator && !forced_ff && rstN && ale != aleD_ff |-> ##[1:12] !power_down_indicator)
    else $error("ale activity did not wake the module");
  chk_force_set: assert property (
    regWr && regAddr == mpdc_pkg::REG3_OFS && regWdata[mpdc_pkg::FORCED_POWERDOWN_BIT_BIT] |-> ##[1:2] power_down_indicator)
    else $error("forced bit did not raise power-down");
  chk_force_hold: assert property (forced_ff && power_down_indicator |=> power_down_indicator)
    else $error("forced power-down left without reset");
  chk_reset_clear: assert property (
    $fell(sys_rst) |-> !power_down_indicator && !turboOff && !regWr && !regRvalid)
    else $error("outputs not idle after power-up reset");
  chk_turbo_set: assert property (
    regWr && regAddr == mpdc_pkg::REG0_OFS |-> ##[1:2] turboOff == regWdata[mpdc_pkg::TURBO_OFF_BIT])
    else $error("turbo flag does not follow register write");
  chk_turbo_keep: assert property ($rose(rstN) && turboOff |=> turboOff [*6])
    else $error("module reset cleared turbo flag");
endmodule : mpdc_chk

/* File: dv/tb_module_power_down_control.sv */
// bench joining host and device ends over the link, ordered through wishbone
// assumes the rtl package, interface and both ends compiled before it
`timescale 1ns/1ns
module tb_module_power_down_control;
  logic ref_clk = 1'b0, sys_rst = 1'b1, wbReq = 1'b0, wbWe = 1'b0, wbAck, clkEn = 1'b1;
  logic csiEnable = 1'b1, logicActive = 1'b0, coreSleep, extraWait, pdnOut, memStandby, busBlock, logicStandby;
  logic [3:0] wbAdr = 4'h0, memDecode = 4'hA, memSelect;
  logic [31:0] wbDatW = 32'h0, wbDatR, rd;
  int n_fail = 0, checks_done = 0;
  mpdc_if mpdc_if_i ();
  mpdc_device mpdc_device_i (.ref_clk, .sys_rst, .clkEn, .link(mpdc_if_i), .csiEnable, .memDecode,
    .logicActive, .memSelect, .powerDownIndicator(pdnOut), .memStandby, .busBlock, .logicStandby);
  mpdc_host #(.COMMON_CLOCK_INPUT_DIV(4), .ALE_DIV(2)) mpdc_host_i (.ref_clk, .sys_rst, .clkEn, .link(mpdc_if_i),
    .wb_cyc_i(wbReq), .wb_stb_i(wbReq), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_dat_i(wbDatW),
    .wb_sel_i(4'hF), .wb_dat_o(wbDatR), .wb_ack_o(wbAck), .coreSleep, .extraWait);
  mpdc_chk mpdc_chk_i (.ref_clk, .sys_rst, .ale(mpdc_if_i.ale), .common_clock_input(mpdc_if_i.common_clock_input), .rstN(mpdc_if_i.rstN),
    .regWr(mpdc_if_i.regWr), .regRd(mpdc_if_i.regRd), .regAddr(mpdc_if_i.regAddr),
    .regWdata(mpdc_if_i.regWdata), .regRvalid(mpdc_if_i.regRvalid), .power_down_indicator(mpdc_if_i.power_down_indicator),
    .turboOff(mpdc_if_i.turboOff));
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic give_up(input string what);
    n_fail++;
    $display("MISMATCH %s expected done seen timeout", what);
    wrap_up();
  endtask : give_up
  // request held until ack is sampled high at a rising edge; data taken and request dropped there
  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat);
    int i;
    @(posedge ref_clk);
    wbReq <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbDatW <= dat;
    i = 0;
    do begin
      @(posedge ref_clk);
      i++;
    end while (wbAck !== 1'b1 && i < 20);
    if (wbAck !== 1'b1) give_up("wishbone ack");
    rd = wbDatR;
    wbReq <= 1'b0;
  endtask : wb
  // control bits: ale run, csN, rstN, common_clock_input run
  task automatic ctrl(input logic [3:0] v);
    wb(1'b1, mpdc_pkg::WB_CTRL, {28'h0, v});
  endtask : ctrl
  task automatic dev(input logic [31:0] cmd);
    int i;
    wb(1'b1, mpdc_pkg::WB_CMD, cmd);
    i = 0;
    do begin
      wb(1'b0, mpdc_pkg::WB_STAT, 32'h0);
      i++;
    end while (rd[mpdc_pkg::STAT_BUSY] !== 1'b0 && i < 20);
    if (rd[mpdc_pkg::STAT_BUSY] !== 1'b0) give_up("link command");
  endtask : dev
  task automatic wait_lvl(input bit sel, input logic lvl, input int lim, output int n);
    n = 0;
    while ((sel ? logicStandby : mpdc_if_i.power_down_indicator) !== lvl) begin
      @(negedge ref_clk);
      n++;
      if (n == lim) give_up("level wait");
    end
  endtask : wait_lvl
  task automatic s_reset();
    wb(1'b0, mpdc_pkg::WB_CTRL, 32'h0);
    check("ctrl", rd, mpdc_pkg::CTRL_RESET);
    wb(1'b0, 4'hC, 32'h0);
    check("unmapped", rd, 32'h0);
    dev({16'h1, mpdc_pkg::REG0_OFS, 8'h00});
    check("reg0", rd[15:8], mpdc_pkg::REG_RESET);
    dev({16'h1, mpdc_pkg::REG3_OFS, 8'h00});
    check("reg3", rd[15:8], mpdc_pkg::REG_RESET);
    check("pdn turbo", {mpdc_if_i.power_down_indicator, mpdc_if_i.turboOff}, 2'b00);
  endtask : s_reset
  task automatic s_auto(input int k);
    int n;
    ctrl(4'hD);
    dev({16'h0, mpdc_pkg::REG0_OFS, 8'h02});
    repeat (200) @(negedge ref_clk);
    check("pdn ale busy", mpdc_if_i.power_down_indicator, 1'b0);
    check("select open", memSelect, memDecode);
    repeat (k) @(negedge ref_clk);
    ctrl(4'hC);
    wait_lvl(1'b0, 1'b1, 300, n);
    check("idle time", n >= 112 && n <= 140, 1'b1);
    @(negedge ref_clk);
    check("pd outs", {memSelect, memStandby, busBlock, pdnOut}, 7'h07);
    ctrl(4'hD);
    wait_lvl(1'b0, 1'b0, 30, n);
    dev({16'h0, mpdc_pkg::REG0_OFS, 8'h00});
  endtask : s_auto
  // clock enable low freezes the select register against a changing decode
  task automatic s_freeze();
    @(posedge ref_clk);
    clkEn <= 1'b0;
    memDecode <= 4'h5;
    repeat (4) @(negedge ref_clk);
    check("frozen select", memSelect, 4'hA);
    @(posedge ref_clk);
    clkEn <= 1'b1;
    repeat (2) @(negedge ref_clk);
    check("select runs", memSelect, 4'h5);
    @(posedge ref_clk);
    memDecode <= 4'hA;
    repeat (2) @(negedge ref_clk);
  endtask : s_freeze
  task automatic s_csi();
    int n;
    ctrl(4'hC);
    repeat (200) @(negedge ref_clk);
    check("pdn auto off", mpdc_if_i.power_down_indicator, 1'b0);
    @(posedge ref_clk);
    csiEnable <= 1'b0;
    ctrl(4'hE);
    repeat (8) @(negedge ref_clk);
    check("select unconfigured", memSelect, memDecode);
    @(posedge ref_clk);
    csiEnable <= 1'b1;
    repeat (3) @(negedge ref_clk);
    check("select chip off", memSelect, 4'h0);
    dev({16'h0, mpdc_pkg::REG0_OFS, 8'h02});
    wait_lvl(1'b0, 1'b1, 300, n);
    ctrl(4'hC);
    wait_lvl(1'b0, 1'b0, 30, n);
    dev({16'h0, mpdc_pkg::REG0_OFS, 8'h00});
  endtask : s_csi
  task automatic s_force();
    int n;
    ctrl(4'h4);
    wb(1'b1, mpdc_pkg::WB_CMD, 32'h0002_0000);
    wait_lvl(1'b0, 1'b1, 10, n);
    repeat (50) @(negedge ref_clk);
    wb(1'b0, mpdc_pkg::WB_STAT, 32'h0);
    check("forced stat", rd[2:1], 2'b11);
    ctrl(4'h0);
    repeat (20) @(negedge ref_clk);
    check("held in reset", mpdc_if_i.power_down_indicator, 1'b1);
    ctrl(4'h4);
    wait_lvl(1'b0, 1'b0, 30, n);
    dev({16'h1, mpdc_pkg::REG3_OFS, 8'h00});
    check("forced cleared", rd[15:8], 8'h00);
  endtask : s_force
  task automatic s_turbo();
    int n;
    @(posedge ref_clk);
    logicActive <= 1'b1;
    dev({16'h0, mpdc_pkg::REG0_OFS, 8'h08});
    check("turbo off", {mpdc_if_i.turboOff, extraWait}, 2'b11);
    @(posedge ref_clk);
    logicActive <= 1'b0;
    wait_lvl(1'b1, 1'b1, 40, n);
    check("standby time", n >= mpdc_pkg::IDLE_5V_CYC && n <= mpdc_pkg::IDLE_5V_CYC + 2, 1'b1);
    ctrl(4'h0);
    ctrl(4'h4);
    repeat (10) @(negedge ref_clk);
    check("turbo kept", mpdc_if_i.turboOff, 1'b1);
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    dev({16'h1, mpdc_pkg::REG0_OFS, 8'h00});
    check("reg0 power-up", rd[15:8], 8'h00);
  endtask : s_turbo
  initial begin
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    s_reset();
    s_auto(0);
    s_auto(2);
    s_freeze();
    s_csi();
    s_force();
    s_turbo();
    wrap_up();
  end
endmodule : tb_module_power_down_control
